// file: pkg/seq_pkg.sv
package seq_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] REQ_OFS = 8'h04;
    localparam logic [7:0] GEOM_OFS = 8'h08;
    localparam logic [7:0] FMT_OFS = 8'h0C;
    localparam logic [7:0] STATUS_BLK_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    // Control bits (write one)
    localparam int CTRL_START = 0;
    localparam int CTRL_RESET = 1;
    localparam int CTRL_CLRIRQ = 2;
    // Status byte fields
    localparam int ST_ERR = 7;
    localparam int ST_SECOND = 0;
    localparam int ST_BADFUNC = 1;
    localparam int ST_NOTREADY = 2;
    localparam int ST_BADPARAM = 3;
    // Function codes
    localparam logic [7:0] F_INIT = 8'h00;
    localparam logic [7:0] F_XSTAT = 8'h01;
    localparam logic [7:0] F_FORMAT = 8'h02;
    localparam logic [7:0] F_RDID = 8'h03;
    localparam logic [7:0] F_READ = 8'h04;
    localparam logic [7:0] F_VERIFY = 8'h05;
    localparam logic [7:0] F_WRITE = 8'h06;
    localparam logic [7:0] F_WRBUF = 8'h07;
    localparam logic [7:0] F_SEEK = 8'h08;
    localparam logic [7:0] F_BUFIO = 8'h0E;
    localparam logic [7:0] F_DIAG = 8'h0F;
    localparam logic [7:0] F_TINIT = 8'h10;
    localparam logic [7:0] F_TREWIND = 8'h11;
    localparam logic [7:0] F_TFILE = 8'h12;
    localparam logic [7:0] F_TMARK = 8'h14;
    localparam logic [7:0] F_TERASE = 8'h17;
    localparam logic [7:0] F_TREC = 8'h1A;
    localparam logic [7:0] F_TRESET = 8'h1C;
    localparam logic [7:0] F_TRETEN = 8'h1D;
    localparam logic [7:0] F_TSTAT = 8'h1E;
    localparam logic [7:0] F_TTERM = 8'h1F;
    localparam logic [7:0] F_MRESET = 8'h80;
    localparam logic [7:0] F_MBACKUP = 8'h81;
    localparam logic [7:0] F_MRESTORE = 8'h82;
    localparam logic [7:0] F_MSTAT = 8'h83;
    localparam logic [7:0] F_MRETEN = 8'h84;
    // Geometry limits, encoding codes and full semaphore value
    localparam logic [15:0] MAX_CYL = 16'h1000;
    localparam logic [7:0] FM_ENC = 8'h00;
    localparam logic [7:0] MFM_ENC = 8'h01;
    localparam logic [7:0] SEM_FULL = 8'hFF;
    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_POST} seq_e;
endpackage : seq_pkg

// file: rtl/disk_tape_function_sequencer.sv
`timescale 1ns/10ps
module disk_tape_function_sequencer
    import seq_pkg::*;
#(
    parameter bit TAPE_EN = 1'b1,
    parameter int DRIVES = 4
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bus_init,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic exec_go,
    output logic [7:0] exec_func,
    output logic [1:0] exec_unit,
    input wire logic exec_done,
    input wire logic exec_err,
    input wire logic lt_done,
    output logic irq
);
    logic init_s1_q, init_s2_q;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [31:0] req_q, req_d, geom_q, geom_d, fmt_q, fmt_d;
    logic [7:0] sem_q, sem_d, ostat_q, ostat_d;
    logic irq_q, irq_d, go_q, go_d;
    logic [7:0] func_q, func_d, mod_q, mod_d;
    logic [1:0] unit_q, unit_d;
    logic [DRIVES-1:0] ready_q, ready_d;
    logic [7:0] altcyl_q [DRIVES], altcyl_d [DRIVES];
    logic lt_pend_q, lt_pend_d, lt_fin_q, lt_fin_d;
    logic [7:0] pst_q, pst_d;
    seq_e state_q, state_d;

    logic acc, wr, start, hard_rst;
    logic [7:0] fn;
    logic known, is_tape, is_lt, floppy;
    logic [15:0] cyl, ssize;
    logic [7:0] spt, heads, enc;
    logic spt_ok, size_ok, geo_ok;

    // INIT comes off a bus pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_s1_q <= 1'b0;
            init_s2_q <= 1'b0;
        end
        else
        begin
            init_s1_q <= bus_init;
            init_s2_q <= init_s1_q;
        end
    end

    assign acc = psel & penable & pready_q;
    assign wr = acc & pwrite & ~pslverr_q;
    assign hard_rst = init_s2_q | (wr && paddr == CTRL_OFS && pwdata[CTRL_RESET]);
    assign fn = req_q[7:0];
    assign floppy = req_q[17];

    always_comb
    begin
        known = 1'b0;
        is_tape = 1'b0;
        case (fn)
            F_INIT, F_XSTAT, F_FORMAT, F_DIAG: known = 1'b1;
            F_RDID, F_READ, F_VERIFY, F_WRITE, F_WRBUF, F_SEEK, F_BUFIO: known = 1'b1;
            F_TINIT, F_TREWIND, F_TFILE, F_TMARK, F_TERASE,
            F_TREC, F_TRESET, F_TRETEN, F_TSTAT, F_TTERM:
            begin
                known = TAPE_EN;
                is_tape = 1'b1;
            end
            F_MRESET, F_MBACKUP, F_MRESTORE, F_MSTAT, F_MRETEN:
            begin
                known = TAPE_EN;
                is_tape = 1'b1;
            end
            default: known = 1'b0;
        endcase
        // Judged on the latched code, the request word may be rewritten meanwhile
        is_lt = is_lt_code(func_q);
    end

    // Initialize parameter checks
    assign cyl = geom_q[15:0];
    assign spt = geom_q[23:16];
    assign heads = geom_q[31:24];
    assign ssize = fmt_q[15:0];
    assign enc = fmt_q[31:24];
    always_comb
    begin
        if (floppy)
            spt_ok = spt == 8'h04 || spt == 8'h08 || spt == 8'h0F || spt == 8'h1A;
        else
            spt_ok = spt == 8'h09 || spt == 8'h11 || spt == 8'h1F || spt == 8'h36;
        size_ok = ssize == 16'h0080 || ssize == 16'h0100 || ssize == 16'h0200 || ssize == 16'h0400;
        geo_ok = spt_ok && size_ok && cyl <= MAX_CYL;
        if (floppy)
            geo_ok = geo_ok && (heads == 8'h01 || heads == 8'h02)
                && (enc == FM_ENC || enc == MFM_ENC);
    end

    // Start only honoured when idle and the last status was taken
    assign start = wr && paddr == CTRL_OFS && pwdata[CTRL_START]
        && state_q == S_IDLE && sem_q == 8'h00;

    always_comb
    begin
        state_d = state_q;
        func_d = func_q;
        unit_d = unit_q;
        mod_d = mod_q;
        ready_d = ready_q;
        altcyl_d = altcyl_q;
        lt_pend_d = lt_pend_q;
        lt_fin_d = lt_fin_q | lt_done;
        pst_d = pst_q;
        sem_d = sem_q;
        ostat_d = ostat_q;
        irq_d = irq_q;
        go_d = 1'b0;
        // Host acknowledges by writing zero
        if (wr && paddr == STATUS_BLK_OFS && pwdata[7:0] == 8'h00)
            sem_d = 8'h00;
        if (wr && paddr == CTRL_OFS && pwdata[CTRL_CLRIRQ])
            irq_d = 1'b0;
        case (state_q)
            S_IDLE:
            begin
                if (start)
                begin
                    func_d = fn;
                    unit_d = req_q[17:16];
                    mod_d = req_q[15:8];
                    pst_d = 8'h00;
                    state_d = S_POST;
                    if (!known)
                        pst_d = 8'h80 | (8'h01 << ST_BADFUNC);
                    else if (fn == F_INIT)
                    begin
                        if (cyl == 16'h0000)
                            ready_d[req_q[17:16]] = 1'b0;
                        else if (geo_ok)
                        begin
                            ready_d[req_q[17:16]] = 1'b1;
                            altcyl_d[req_q[17:16]] = fmt_q[23:16];
                        end
                        else
                        begin
                            ready_d[req_q[17:16]] = 1'b0;
                            pst_d = 8'h80 | (8'h01 << ST_BADPARAM);
                        end
                    end
                    else if (!is_tape && !ready_q[req_q[17:16]])
                        pst_d = 8'h80 | (8'h01 << ST_NOTREADY);
                    else
                    begin
                        go_d = 1'b1;
                        state_d = S_EXEC;
                    end
                end
                // Second posting only with nothing in flight
                else if (lt_pend_q && lt_fin_q && sem_q == 8'h00)
                begin
                    sem_d = SEM_FULL;
                    ostat_d = 8'h01 << ST_SECOND;
                    irq_d = 1'b1;
                    lt_pend_d = 1'b0;
                    lt_fin_d = 1'b0;
                end
            end
            S_EXEC:
            begin
                if (exec_done)
                begin
                    pst_d = exec_err ? 8'h80 : 8'h00;
                    state_d = S_POST;
                end
            end
            S_POST:
            begin
                if (sem_q == 8'h00)
                begin
                    sem_d = SEM_FULL;
                    ostat_d = pst_q;
                    if (mod_q[0])
                        irq_d = 1'b1;
                    // Error ends a long-term function here
                    if (is_lt && !pst_q[ST_ERR])
                        lt_pend_d = 1'b1;
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
        if (hard_rst)
        begin
            ready_d = '0;
            irq_d = 1'b0;
            lt_pend_d = 1'b0;
            lt_fin_d = 1'b0;
            state_d = S_IDLE;
        end
    end

    function automatic logic is_lt_code(input logic [7:0] f);
        is_lt_code = (f == F_SEEK) || (f == F_TFILE) || (f == F_TRETEN)
            || (f == F_TREWIND) || (f == F_TERASE);
    endfunction : is_lt_code

    // Register bus: one wait state so read data comes from a flop
    always_comb
    begin
        req_d = req_q;
        geom_d = geom_q;
        fmt_d = fmt_q;
        pready_d = psel & penable & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        case (paddr)
            CTRL_OFS: prdata_d = 32'h0000_0000;
            REQ_OFS: prdata_d = req_q;
            GEOM_OFS: prdata_d = geom_q;
            FMT_OFS: prdata_d = fmt_q;
            STATUS_BLK_OFS: prdata_d = {16'h0000, ostat_q, sem_q};
            STAT_OFS: prdata_d = {16'h0000, altcyl_q[req_q[17:16]], 1'b0, lt_fin_q, lt_pend_q,
                state_q != S_IDLE, ready_q};
            default: pslverr_d = pready_d;
        endcase
        if (wr && paddr == REQ_OFS)
            req_d = pwdata;
        if (wr && paddr == GEOM_OFS)
            geom_d = pwdata;
        if (wr && paddr == FMT_OFS)
            fmt_d = pwdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            req_q <= 32'h0000_0000;
            geom_q <= 32'h0000_0000;
            fmt_q <= 32'h0000_0000;
            state_q <= S_IDLE;
            func_q <= 8'h00;
            unit_q <= 2'h0;
            mod_q <= 8'h00;
            ready_q <= '0;
            for (int i = 0; i < DRIVES; i++)
                altcyl_q[i] <= 8'h00;
            lt_pend_q <= 1'b0;
            lt_fin_q <= 1'b0;
            pst_q <= 8'h00;
            sem_q <= 8'h00;
            ostat_q <= 8'h00;
            irq_q <= 1'b0;
            go_q <= 1'b0;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            req_q <= req_d;
            geom_q <= geom_d;
            fmt_q <= fmt_d;
            state_q <= state_d;
            func_q <= func_d;
            unit_q <= unit_d;
            mod_q <= mod_d;
            ready_q <= ready_d;
            altcyl_q <= altcyl_d;
            lt_pend_q <= lt_pend_d;
            lt_fin_q <= lt_fin_d;
            pst_q <= pst_d;
            sem_q <= sem_d;
            ostat_q <= ostat_d;
            irq_q <= irq_d;
            go_q <= go_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign exec_go = go_q;
    assign exec_func = func_q;
    assign exec_unit = unit_q;
    assign irq = irq_q;
endmodule : disk_tape_function_sequencer

// file: tb/exec_engine_model.sv
`timescale 1ns/10ps
module exec_engine_model
    import seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic exec_go,
    input wire logic [7:0] exec_func,
    input wire logic [1:0] exec_unit,
    output logic exec_done,
    output logic exec_err,
    output logic lt_done
);
    int cnt;
    int ltc;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            ltc <= 0;
            exec_done <= 1'b0;
            exec_err <= 1'b0;
            lt_done <= 1'b0;
        end
        else
        begin
            exec_done <= cnt == 1;
            // Unit 3 always fails, to reach the error paths
            exec_err <= cnt == 1 && exec_unit == 2'd3;
            lt_done <= ltc == 1;
            cnt <= exec_go ? 4 : (cnt > 0 ? cnt - 1 : 0);
            // Failed long-term work never finishes physically
            if (cnt == 1 && exec_unit != 2'd3 && (exec_func inside {F_SEEK, F_TFILE, F_TRETEN, F_TREWIND, F_TERASE}))
                ltc <= 60;
            else if (ltc > 0)
                ltc <= ltc - 1;
        end
    end
endmodule : exec_engine_model

// file: tb/disk_tape_function_sequencer_asserts.sv
`timescale 1ns/10ps
module seq_checker
    import seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bus_init,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic exec_go,
    input wire logic [7:0] exec_func,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable && pready;
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    pready_wait_a: assert property (psel && $rose(penable) |=> pready) else $error("pready late");
    slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    unmapped_err_a: assert property (acc && paddr > STAT_OFS |-> pslverr) else $error("unmapped not refused");
    ctrl_reads_zero_a: assert property (acc && !pwrite && paddr == CTRL_OFS |-> prdata == 32'h0)
        else $error("control read not zero");
    go_pulse_a: assert property (exec_go |=> !exec_go) else $error("exec_go not a pulse");
    go_cause_a: assert property (exec_go
        |-> $past(acc && pwrite && paddr == CTRL_OFS && pwdata[CTRL_START])) else $error("exec_go without start");
    // Code latches on every accepted start, executed or refused
    func_stable_a: assert property ($changed(exec_func)
        |-> $past(acc && pwrite && paddr == CTRL_OFS && pwdata[CTRL_START])) else $error("exec_func moved");
    irq_hold_a: assert property ($fell(irq)
        |-> $past(acc && pwrite && paddr == CTRL_OFS && (pwdata[CTRL_CLRIRQ] || pwdata[CTRL_RESET]))
        || $past(bus_init, 2) || $past(bus_init, 3) || $past(bus_init, 4)) else $error("irq dropped");
endmodule : seq_checker
bind disk_tape_function_sequencer seq_checker seq_checker_i (.pclk, .presetn, .bus_init, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exec_go, .exec_func, .irq);

// file: tb/disk_tape_function_sequencer_test.sv
`timescale 1ns/10ps
module disk_tape_function_sequencer_test
    import seq_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic bus_init = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, exec_go, exec_done, exec_err, lt_done, irq, serr;
    logic [7:0] exec_func;
    logic [1:0] exec_unit;
    logic [31:0] rd;
    logic [7:0] st;
    int fails = 0;
    int cmp_count = 0;
    logic [7:0] codes [25] = '{F_XSTAT, F_FORMAT, F_RDID, F_READ, F_VERIFY, F_WRITE, F_WRBUF, F_SEEK, F_BUFIO,
        F_DIAG, F_TINIT, F_TREWIND, F_TFILE, F_TMARK, F_TERASE, F_TREC, F_TRESET, F_TRETEN, F_TSTAT, F_TTERM,
        F_MRESET, F_MBACKUP, F_MRESTORE, F_MSTAT, F_MRETEN};
    always #5 pclk = ~pclk;
    disk_tape_function_sequencer disk_tape_function_sequencer_i (.pclk, .presetn, .bus_init, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exec_go, .exec_func, .exec_unit, .exec_done,
        .exec_err, .lt_done, .irq);
    exec_engine_model exec_engine_model_i (.pclk, .presetn, .exec_go, .exec_func, .exec_unit, .exec_done,
        .exec_err, .lt_done);
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50)
            fails++;
    endtask : apb
    // Waits for the semaphore; leaves it set so the caller picks when to ack
    task automatic poll();
        int n;
        n = 0;
        do apb(1'b0, STATUS_BLK_OFS, 32'h0); while (rd[7:0] === 8'h00 && ++n < 100);
        if (n == 100)
            fails++;
        st = rd[15:8];
    endtask : poll
    task automatic start(input logic [7:0] f, input logic [1:0] u, input logic m);
        apb(1'b1, REQ_OFS, {14'h0, u, 7'h0, m, f});
        apb(1'b1, CTRL_OFS, 32'h1);
        poll();
    endtask : start
    task automatic run(input logic [7:0] f, input logic [1:0] u, input logic m, input logic [7:0] e);
        start(f, u, m);
        cmp("status", {24'h0, e}, {24'h0, st});
        apb(1'b1, STATUS_BLK_OFS, 32'h0);
    endtask : run
    task automatic init(input logic [1:0] u, input logic [31:0] g, input logic [31:0] fm, input logic [7:0] e);
        apb(1'b1, GEOM_OFS, g);
        apb(1'b1, FMT_OFS, fm);
        run(F_INIT, u, 1'b0, e);
    endtask : init
    initial
    begin
        #500000;
        fails++;
        print_verdict();
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        run(F_READ, 2'd0, 1'b0, 8'h84);
        init(2'd0, {8'd4, 8'd10, 16'd4096}, {8'h0, 8'd5, 16'd512}, 8'h88);
        init(2'd0, {8'd4, 8'd17, 16'd4097}, {8'h0, 8'd5, 16'd512}, 8'h88);
        init(2'd0, {8'd4, 8'd54, 16'd4096}, {8'h0, 8'd5, 16'd1024}, 8'h00);
        apb(1'b0, STAT_OFS, 32'h0);
        cmp("stat", 32'h0501, rd & 32'hFFFF);
        init(2'd3, {8'd2, 8'd26, 16'd77}, {8'h02, 8'd0, 16'd256}, 8'h88);
        init(2'd3, {8'd2, 8'd26, 16'd77}, {8'h01, 8'd0, 16'd300}, 8'h88);
        init(2'd3, {8'd2, 8'd9, 16'd77}, {8'h01, 8'd0, 16'd256}, 8'h88);
        init(2'd3, {8'd3, 8'd26, 16'd77}, {8'h01, 8'd0, 16'd256}, 8'h88);
        init(2'd3, {8'd2, 8'd26, 16'd77}, {8'h01, 8'd0, 16'd256}, 8'h00);
        init(2'd2, {8'd1, 8'd4, 16'd77}, {8'h00, 8'd0, 16'd128}, 8'h00);
        run(8'h09, 2'd2, 1'b0, 8'h82);
        run(8'h85, 2'd2, 1'b0, 8'h82);
        foreach (codes[i])
        begin
            run(codes[i], 2'd2, 1'b1, 8'h00);
            cmp("irq", 32'h1, {31'h0, irq});
            cmp("func", {24'h0, codes[i]}, {24'h0, exec_func});
            cmp("unit", 32'h2, {30'h0, exec_unit});
            apb(1'b1, CTRL_OFS, 32'h4);
            if (codes[i] inside {F_SEEK, F_TFILE, F_TRETEN, F_TREWIND, F_TERASE})
            begin
                poll();
                cmp("second", 32'h1, {24'h0, st});
                apb(1'b1, STATUS_BLK_OFS, 32'h0);
                apb(1'b1, CTRL_OFS, 32'h4);
            end
        end
        run(F_SEEK, 2'd0, 1'b0, 8'h00);
        cmp("irq", 32'h0, {31'h0, irq});
        start(F_READ, 2'd2, 1'b0);
        cmp("inter", 32'h0, {24'h0, st});
        cmp("irq", 32'h0, {31'h0, irq});
        repeat (100) @(posedge pclk);
        apb(1'b0, STATUS_BLK_OFS, 32'h0);
        cmp("held", 32'h00FF, rd & 32'hFFFF);
        apb(1'b1, STATUS_BLK_OFS, 32'h0);
        poll();
        cmp("second", 32'h1, {24'h0, st});
        cmp("irq", 32'h1, {31'h0, irq});
        apb(1'b1, STATUS_BLK_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h4);
        run(F_SEEK, 2'd3, 1'b1, 8'h80);
        repeat (100) @(posedge pclk);
        apb(1'b0, STATUS_BLK_OFS, 32'h0);
        cmp("nosecond", 32'h0, rd & 32'hFF);
        cmp("irq", 32'h1, {31'h0, irq});
        init(2'd2, {8'd1, 8'd4, 16'd0}, {8'h00, 8'd0, 16'd128}, 8'h00);
        run(F_READ, 2'd2, 1'b0, 8'h84);
        cmp("irq", 32'h1, {31'h0, irq});
        @(posedge pclk) bus_init <= 1'b1;
        repeat (3) @(posedge pclk);
        bus_init <= 1'b0;
        apb(1'b0, STAT_OFS, 32'h0);
        cmp("ready", 32'h0, rd & 32'hF);
        cmp("irq", 32'h0, {31'h0, irq});
        run(F_READ, 2'd0, 1'b0, 8'h84);
        init(2'd1, {8'd2, 8'd9, 16'd100}, {8'h00, 8'd3, 16'd512}, 8'h00);
        apb(1'b0, STAT_OFS, 32'h0);
        cmp("stat", 32'h0302, rd & 32'hFFFF);
        apb(1'b1, CTRL_OFS, 32'h2);
        apb(1'b0, STAT_OFS, 32'h0);
        cmp("ready", 32'h0, rd & 32'hF);
        apb(1'b0, 8'h18, 32'h0);
        cmp("slverr", 32'h1, {31'h0, serr});
        print_verdict();
    end
endmodule : disk_tape_function_sequencer_test
